// [design/vd_pkg.sv]
// Constants, register map and command codes of the dual-port video DRAM controller.
// Assumes a 40 MHz system clock; random-port pin timing is counted in whole cycles of it, serial clock timing in link clock cycles.
package vd_pkg;

  localparam int CLK_MHZ = 40;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction : max3

  // Pin timing in ns, slowest speed grade.
  localparam int T_PWRUP_NS = 100000;
  localparam int T_RAS_NS   = 70;
  localparam int T_RP_NS    = 50;
  localparam int T_RCD_NS   = 30;
  localparam int T_CAC_NS   = 18;
  localparam int T_RWD_NS   = 90;
  localparam int T_CWD_NS   = 40;
  localparam int T_AWD_NS   = 55;
  localparam int T_RDH_NS   = 60;
  localparam int T_RDHS_NS  = 15;
  localparam int T_OED_NS   = 15;
  localparam int T_WP_NS    = 12;
  localparam int T_CAS_NS   = 15;
  localparam int T_CSR_NS   = 5;
  localparam int T_OFF_NS   = 15;

  // Input synchroniser latency: three stages and the agreement register.
  localparam int SYNC_LAT     = 4;
  localparam int PWRUP_CYCLES = cyc_min(T_PWRUP_NS);
  localparam int DUMMY_CYCLES = 8;
  localparam int RAS_CYC      = cyc_min(T_RAS_NS);
  localparam int RP_CYC       = cyc_min(T_RP_NS);
  localparam int RCD_CYC      = cyc_min(T_RCD_NS);
  localparam int RD_CYC       = cyc_min(T_CAC_NS) + SYNC_LAT;
  localparam int RDH_CYC      = cyc_min(T_RDH_NS);
  localparam int RDHS_CYC     = cyc_min(T_RDHS_NS);
  localparam int OED_CYC      = cyc_min(T_OED_NS);
  localparam int WP_CYC       = cyc_min(T_WP_NS);
  localparam int CAS_CYC      = cyc_min(T_CAS_NS);
  localparam int CSR_CYC      = cyc_min(T_CSR_NS);
  localparam int OFF_CYC      = cyc_min(T_OFF_NS);
  // One spare cycle keeps the write enable clear of the undefined middle zone.
  localparam int WE_DLY_CYC   = max3(cyc_min(T_RWD_NS) - RCD_CYC, cyc_min(T_CWD_NS),
                                     cyc_min(T_AWD_NS)) + 1;
  localparam int RMW_DLY_CYC  = (WE_DLY_CYC > RD_CYC) ? WE_DLY_CYC : RD_CYC;
  localparam int SC_HALF_CYC  = 4;

  // Register byte offsets.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_SCTRL  = 5'h14;
  localparam logic [4:0] REG_SDATA  = 5'h18;

  // Field positions.
  localparam int CTRL_GO    = 0;
  localparam int CTRL_CMD   = 1;
  localparam int CTRL_EDO   = 4;
  localparam int CTRL_UB    = 5;
  localparam int CTRL_LB    = 6;
  localparam int CTRL_SELF  = 7;
  localparam int CTRL_BLOCK = 8;
  localparam int SCTRL_RUN  = 0;
  localparam int SCTRL_WR   = 1;
  localparam int SCTRL_TAP  = 2;
  localparam int SCTRL_STOP = 3;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_INIT  = 1;
  localparam int STAT_REFD  = 2;
  localparam int STAT_STOP  = 3;
  localparam int STAT_HALF  = 4;
  localparam int STAT_SVAL  = 5;

  // Values after reset and after initialisation.
  localparam logic [15:0] MASK_INIT  = 16'hffff;
  localparam logic [8:0]  STOP_INIT  = 9'h1ff;
  localparam logic [11:0] SCTRL_RST  = 12'h000;

  typedef enum logic [2:0] {
    CMD_READ  = 3'h0,
    CMD_EARLY = 3'h1,
    CMD_LATE  = 3'h2,
    CMD_RMW   = 3'h3,
    CMD_REF   = 3'h4,
    CMD_XFER  = 3'h5,
    CMD_SPLIT = 3'h6,
    CMD_STOP  = 3'h7
  } vd_cmd_t;

endpackage : vd_pkg

// [design/vd_sync.sv]
// Three-stage synchroniser; a bit changes only once stages two and three agree.
// Assumes each bit is a level or a toggle that stays put for several destination clocks.
`timescale 1ns/1ps
module vd_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] f1_r;
  logic [W-1:0] f2_r;
  logic [W-1:0] f3_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      f1_r <= '0;
      f2_r <= '0;
      f3_r <= '0;
      o_q  <= '0;
    end else begin
      f1_r <= i_d;
      f2_r <= f1_r;
      f3_r <= f2_r;
      o_q  <= (f3_r & ~(f2_r ^ f3_r)) | (o_q & (f2_r ^ f3_r));
    end
  end
endmodule : vd_sync

// [design/vd_serial.sv]
// Serial-port reader and writer running on the link clock.
// Assumes run, hold and ack come from the system domain, and that the stop column and
// write word stay still while they are used; each word passes by a req/ack toggle.
`timescale 1ns/1ps
module vd_serial import vd_pkg::*; #(
  parameter int SC_HALF = SC_HALF_CYC
) (
  // Link clock and reset
  input  wire logic        i_lclk,
  input  wire logic        i_rst,
  // Control from the system domain
  input  wire logic        i_run,
  input  wire logic        i_hold,
  input  wire logic        i_wr_mode,
  input  wire logic        i_ack_tgl,
  input  wire logic [8:0]  i_stop_col,
  input  wire logic [15:0] i_wr_word,
  // Serial pins
  input  wire logic [15:0] i_sio,
  output logic             o_sc,
  output logic             o_se_n,
  output logic      [15:0] o_sio,
  output logic             o_sio_oe,
  // Status to the system domain
  output logic      [15:0] o_rd_word,
  output logic             o_req_tgl,
  output logic             o_hold_ack,
  output logic             o_at_stop
);
  typedef enum logic [1:0] {S_WAIT = 2'b00, S_HI = 2'b01, S_LO = 2'b10} vd_sst_t;

  if (SC_HALF < 1 || SC_HALF > 255) begin : g_bad_half
    $error("SC_HALF must lie in 1..255");
  end

  vd_sst_t     st_r;
  logic [7:0]  cnt_r;
  logic [8:0]  ptr_r;
  logic [2:0]  ctl_s;
  logic [15:0] sio_s;

  vd_sync #(.W(3)) u_ctl_sync (
    .i_clk (i_lclk),
    .i_rst (i_rst),
    .i_d   ({i_run, i_hold, i_ack_tgl}),
    .o_q   (ctl_s)
  );

  vd_sync #(.W(16)) u_sio_sync (
    .i_clk (i_lclk),
    .i_rst (i_rst),
    .i_d   (i_sio),
    .o_q   (sio_s)
  );

  // The pointer runs whatever the random port does; hold, an unacknowledged word or run low (which clears it) stops it.
  always_ff @(posedge i_lclk or posedge i_rst) begin // RL13
    if (i_rst) begin
      st_r       <= S_WAIT;
      cnt_r      <= 8'h00;
      ptr_r      <= 9'h000;
      o_sc       <= 1'b0;
      o_se_n     <= 1'b1;
      o_sio      <= 16'h0000;
      o_sio_oe   <= 1'b0;
      o_rd_word  <= 16'h0000;
      o_req_tgl  <= 1'b0;
      o_hold_ack <= 1'b0;
    end else begin
      case (st_r)
        S_WAIT: begin
          o_se_n <= ~ctl_s[2];
          // Hold is only acknowledged between edges, so no rising edge follows it.
          o_hold_ack <= ctl_s[1]; // RL11
          if (!ctl_s[2]) begin
            ptr_r <= 9'h000;
          end else if (!ctl_s[1] && (ctl_s[0] == o_req_tgl)) begin
            o_sc     <= 1'b1;
            o_sio_oe <= i_wr_mode;
            o_sio    <= i_wr_word;
            cnt_r    <= 8'(SC_HALF - 1);
            st_r     <= S_HI;
          end
        end
        S_HI: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            o_sc      <= 1'b0;
            ptr_r     <= ptr_r + 9'h001;
            cnt_r     <= 8'(SC_HALF - 1);
            st_r      <= S_LO;
          end
        end
        S_LO: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            o_sio_oe  <= 1'b0;
            // Sampled late so the synchronised word belongs to this clock edge.
            o_rd_word <= sio_s;
            o_req_tgl <= ~o_req_tgl;
            st_r      <= S_WAIT;
          end
        end
        default: st_r <= S_WAIT;
      endcase
    end
  end

  always_ff @(posedge i_lclk or posedge i_rst) begin
    if (i_rst) begin
      o_at_stop <= 1'b0;
    end else begin
      o_at_stop <= i_wr_mode & ctl_s[2] & (ptr_r == i_stop_col);
    end
  end
endmodule : vd_serial

// [design/vd_ctrl.sv]
// Host controller for a 256K x 16 dual-port video DRAM, driven from Avalon-MM registers.
// Assumes the bench resolves the bidirectional data wires from the output enables and
// supplies an unrelated link clock for the serial port.
// Function
// RL1 - After power-up wait beyond the settling time, then run eight RAS-only dummy cycles.
// RL2 - Write enable low before CAS falls gives an early write with device data pins floated; here write enable falls on the same edge as CAS.
// RL3 - Write enable falling late enough gives read-modify-write with read data driven first.
// RL4 - Write enable timing between early and read-modify-write leaves the pins undefined.
// RL5 - Write data is taken at CAS fall for early write and at write enable fall otherwise.
// RL6 - A read transfer is timed either by the transfer/output-enable edge or by itself.
// RL7 - Standard variant floats read data at CAS rise, output enable rise or write enable fall.
// RL8 - Extended-data-out variant floats only once both strobes are high, from the later rise.
// RL9 - Serial clock must be held around RAS in stop-set cycles when stop changes with taps used.
// RL10 - In a split transfer with boundary jump the pointer moves source to destination.
// RL11 - No serial clock rising edge between the jump source and jump destination edges.
// RL12 - No split transfer starts while the serial port writes the stop column.
// RL13 - The serial port runs independently of random-port cycles.
// RL14 - Function select high makes a block write with column data, low an ordinary write.
// RL15 - After initialisation the bit mask and stop register are all ones.
`timescale 1ns/1ps
module vd_ctrl import vd_pkg::*; #(
  parameter int PWRUP_CYC = PWRUP_CYCLES
) (
  // System clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Random port pins
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_upper_byte_write_enable_n,
  output logic             o_lower_byte_write_enable_n,
  output logic             o_transfer_output_enable_n,
  output logic             o_function_select,
  output logic      [8:0]  o_addr,
  output logic      [15:0] o_dq,
  output logic             o_dq_oe,
  input  wire logic [15:0] i_dq,
  // Serial port pins and link clock
  input  wire logic        i_lclk,
  output logic             o_serial_clock_pin,
  output logic             o_serial_enable_pin_n,
  output logic      [15:0] o_serial_data_pins,
  output logic             o_serial_data_pins_oe,
  input  wire logic [15:0] i_serial_data_pins,
  input  wire logic        i_serial_half_flag
);
  typedef enum logic [3:0] {
    ST_PWR  = 4'h0, ST_DRAS = 4'h1, ST_DPRE = 4'h2, ST_IDLE = 4'h3,
    ST_HOLD = 4'h4, ST_CBR  = 4'h5, ST_REF  = 4'h6, ST_ROW  = 4'h7,
    ST_COL  = 4'h8, ST_WSET = 4'h9, ST_WE   = 4'ha, ST_END  = 4'hb,
    ST_PRE  = 4'hc
  } vd_st_t;

  if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) begin : g_bad_pwr
    $error("PWRUP_CYC must lie in 1..65535");
  end

  vd_st_t      st_r;
  vd_cmd_t     cmd_r;
  logic [15:0] cnt_r;
  logic [2:0]  dummy_r;
  logic [8:0]  ctrl_r;
  logic [17:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [11:0] sctrl_r;
  logic [15:0] swr_r;
  logic [15:0] sdata_r;
  logic        svalid_r;
  logic        init_r;
  logic        refused_r;
  logic        hold_r;
  logic        go_r;
  logic        ack_r;
  logic        sack_r;
  logic [15:0] mask_r;
  logic [8:0]  stop_r;
  logic [15:0] dq_s;
  logic [3:0]  st_s;
  logic [15:0] srd_word;
  logic        sreq_tgl;
  logic        shold_ack;
  logic        sat_stop;
  logic        acc;
  logic        wr_acc;
  logic        is_wr;

  assign acc               = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_waitrequest = acc;
  assign wr_acc            = i_avs_write & ack_r;
  assign is_wr             = (cmd_r == CMD_EARLY) | (cmd_r == CMD_LATE) | (cmd_r == CMD_RMW);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  vd_sync #(.W(16)) u_dq_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_dq),
    .o_q   (dq_s)
  );

  vd_sync #(.W(4)) u_st_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({sreq_tgl, shold_ack, sat_stop, i_serial_half_flag}),
    .o_q   (st_s)
  );

  vd_serial u_serial (
    .i_lclk     (i_lclk),
    .i_rst      (i_rst),
    .i_run      (sctrl_r[SCTRL_RUN]),
    .i_hold     (hold_r),
    .i_wr_mode  (sctrl_r[SCTRL_WR]),
    .i_ack_tgl  (sack_r),
    .i_stop_col (sctrl_r[SCTRL_STOP +: 9]),
    .i_wr_word  (swr_r),
    .i_sio      (i_serial_data_pins),
    .o_sc       (o_serial_clock_pin),
    .o_se_n     (o_serial_enable_pin_n),
    .o_sio      (o_serial_data_pins),
    .o_sio_oe   (o_serial_data_pins_oe),
    .o_rd_word  (srd_word),
    .o_req_tgl  (sreq_tgl),
    .o_hold_ack (shold_ack),
    .o_at_stop  (sat_stop)
  );

  // Bus slave: one wait cycle, the answer stands at the edge waitrequest is low.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r          <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= acc;
      case (i_avs_address)
        REG_CTRL:   o_avs_readdata <= {23'h000000, ctrl_r};
        REG_ADDR:   o_avs_readdata <= {14'h0000, addr_r};
        REG_WDATA:  o_avs_readdata <= {16'h0000, wdata_r};
        REG_RDATA:  o_avs_readdata <= {16'h0000, rdata_r};
        REG_STATUS: o_avs_readdata <= {stop_r, 1'b0, mask_r, svalid_r, st_s[0], st_s[1],
                                       refused_r, init_r, (st_r != ST_IDLE)};
        REG_SCTRL:  o_avs_readdata <= {4'h0, swr_r, sctrl_r};
        REG_SDATA:  o_avs_readdata <= {16'h0000, sdata_r};
        default:    o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r  <= 9'h000;
      addr_r  <= 18'h00000;
      wdata_r <= 16'h0000;
      sctrl_r <= SCTRL_RST;
      swr_r   <= 16'h0000;
      go_r    <= 1'b0;
    end else begin
      go_r <= wr_acc & (i_avs_address == REG_CTRL) & i_avs_writedata[CTRL_GO]
              & i_avs_byteenable[0];
      if (wr_acc) begin
        case (i_avs_address)
          REG_CTRL: begin
            ctrl_r <= 9'(be_merge({23'h000000, ctrl_r}, i_avs_writedata, i_avs_byteenable)
                         & 32'h0000_01fe);
          end
          REG_ADDR:  addr_r  <= 18'(be_merge({14'h0000, addr_r}, i_avs_writedata,
                                             i_avs_byteenable));
          REG_WDATA: wdata_r <= 16'(be_merge({16'h0000, wdata_r}, i_avs_writedata,
                                             i_avs_byteenable));
          REG_SCTRL: {swr_r, sctrl_r} <= 28'(be_merge({4'h0, swr_r, sctrl_r},
                                                      i_avs_writedata, i_avs_byteenable));
          default: ;
        endcase
      end
    end
  end

  // Serial words: a read word waits in sdata_r until software takes it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sdata_r  <= 16'h0000;
      svalid_r <= 1'b0;
      sack_r   <= 1'b0;
    end else begin
      if (st_s[3] != sack_r && (sctrl_r[SCTRL_WR] || !svalid_r)) begin
        sdata_r  <= srd_word;
        svalid_r <= ~sctrl_r[SCTRL_WR];
        sack_r   <= ~sack_r;
      end else if (i_avs_read && ack_r && i_avs_address == REG_SDATA) begin
        svalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r    <= ST_PWR;
      cmd_r   <= CMD_READ;
      cnt_r   <= 16'(PWRUP_CYC);
      dummy_r <= 3'h0;
      init_r  <= 1'b0;
      refused_r <= 1'b0;
      hold_r  <= 1'b0;
      rdata_r <= 16'h0000;
      mask_r  <= 16'h0000;
      stop_r  <= 9'h000;
      o_ras_n <= 1'b1;
      o_cas_n <= 1'b1;
      o_upper_byte_write_enable_n <= 1'b1;
      o_lower_byte_write_enable_n <= 1'b1;
      o_transfer_output_enable_n  <= 1'b1;
      o_function_select <= 1'b0;
      o_addr  <= 9'h000;
      o_dq    <= 16'h0000;
      o_dq_oe <= 1'b0;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end else begin
      case (st_r)
        ST_PWR: begin
          o_ras_n <= 1'b0; // RL1
          cnt_r   <= 16'(RAS_CYC - 1);
          st_r    <= ST_DRAS;
        end
        ST_DRAS: begin
          o_ras_n <= 1'b1;
          cnt_r   <= 16'(RP_CYC - 1);
          st_r    <= ST_DPRE;
        end
        ST_DPRE: begin
          if (dummy_r == 3'(DUMMY_CYCLES - 1)) begin // RL1
            init_r <= 1'b1;
            mask_r <= MASK_INIT; // RL15
            stop_r <= STOP_INIT; // RL15
            st_r   <= ST_IDLE;
          end else begin
            dummy_r <= dummy_r + 3'h1;
            o_ras_n <= 1'b0;
            cnt_r   <= 16'(RAS_CYC - 1);
            st_r    <= ST_DRAS;
          end
        end
        ST_IDLE: begin
          if (go_r) begin
            cmd_r <= vd_cmd_t'(ctrl_r[CTRL_CMD +: 3]);
            if (vd_cmd_t'(ctrl_r[CTRL_CMD +: 3]) == CMD_SPLIT && st_s[1]) begin
              refused_r <= 1'b1; // RL12
            end else begin
              refused_r <= 1'b0;
              hold_r <= (vd_cmd_t'(ctrl_r[CTRL_CMD +: 3]) == CMD_SPLIT) // RL11
                        | ((vd_cmd_t'(ctrl_r[CTRL_CMD +: 3]) == CMD_STOP)
                           & (addr_r[8:0] != stop_r) & sctrl_r[SCTRL_TAP]); // RL9
              st_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (hold_r == st_s[2]) begin
            o_addr <= addr_r[17:9];
            o_function_select <= 1'b0;
            case (cmd_r)
              CMD_REF: begin
                o_ras_n <= 1'b0;
                cnt_r   <= 16'(RAS_CYC - 1);
                st_r    <= ST_REF;
              end
              CMD_STOP: begin
                o_cas_n <= 1'b0;
                o_addr  <= addr_r[8:0];
                cnt_r   <= 16'(CSR_CYC - 1);
                st_r    <= ST_CBR;
              end
              default: begin
                o_ras_n <= 1'b0;
                o_transfer_output_enable_n <= ~((cmd_r == CMD_XFER) | (cmd_r == CMD_SPLIT));
                cnt_r   <= 16'(RCD_CYC - 1);
                st_r    <= ST_ROW;
              end
            endcase
          end
        end
        ST_CBR: begin
          o_ras_n <= 1'b0;
          stop_r  <= addr_r[8:0];
          cnt_r   <= 16'(RAS_CYC - 1);
          st_r    <= ST_REF;
        end
        ST_REF: begin
          o_ras_n <= 1'b1;
          o_cas_n <= 1'b1;
          cnt_r   <= 16'(RP_CYC - 1);
          st_r    <= ST_PRE;
        end
        ST_ROW: begin
          o_cas_n <= 1'b0;
          o_addr  <= addr_r[8:0];
          o_function_select <= is_wr & ctrl_r[CTRL_BLOCK]; // RL14
          // Reads open the outputs here; transfers stay low, plain writes stay high.
          o_transfer_output_enable_n <= is_wr & (cmd_r != CMD_RMW);
          st_r    <= ST_COL;
          case (cmd_r)
            CMD_EARLY: begin
              // Enables and data settle on the CAS fall edge itself.
              o_upper_byte_write_enable_n <= ~ctrl_r[CTRL_UB]; // RL2
              o_lower_byte_write_enable_n <= ~ctrl_r[CTRL_LB]; // RL2
              o_dq    <= wdata_r; // RL5
              o_dq_oe <= 1'b1;
              cnt_r   <= 16'(CAS_CYC - 1);
            end
            CMD_LATE: cnt_r <= 16'(WE_DLY_CYC - 1); // RL4
            CMD_RMW:  cnt_r <= 16'(RMW_DLY_CYC - 1); // RL3
            CMD_XFER, CMD_SPLIT: begin
              cnt_r <= ctrl_r[CTRL_SELF] ? 16'(RDHS_CYC - 1) : 16'(RDH_CYC - 1); // RL6
            end
            default: cnt_r <= 16'(RD_CYC - 1);
          endcase
        end
        ST_COL: begin
          case (cmd_r)
            CMD_READ: begin
              rdata_r <= dq_s;
              st_r    <= ST_END;
            end
            CMD_LATE: begin
              o_dq  <= wdata_r;
              cnt_r <= 16'h0000;
              st_r  <= ST_WSET;
            end
            CMD_RMW: begin
              rdata_r <= dq_s; // RL3
              // Raising output enable floats the device before the host drives.
              o_transfer_output_enable_n <= 1'b1; // RL7
              o_dq  <= wdata_r;
              cnt_r <= 16'(OED_CYC - 1);
              st_r  <= ST_WSET;
            end
            CMD_XFER, CMD_SPLIT: begin
              o_transfer_output_enable_n <= 1'b1; // RL6
              st_r <= ST_END;
            end
            default: st_r <= ST_END;
          endcase
        end
        ST_WSET: begin
          o_dq_oe <= 1'b1;
          o_upper_byte_write_enable_n <= ~ctrl_r[CTRL_UB]; // RL5
          o_lower_byte_write_enable_n <= ~ctrl_r[CTRL_LB]; // RL5
          cnt_r <= 16'(WP_CYC - 1);
          st_r  <= ST_WE;
        end
        ST_WE: begin
          st_r <= ST_END;
        end
        ST_END: begin
          o_cas_n <= 1'b1;
          o_ras_n <= ~ctrl_r[CTRL_EDO];
          o_dq_oe <= 1'b0;
          o_upper_byte_write_enable_n <= 1'b1;
          o_lower_byte_write_enable_n <= 1'b1;
          o_transfer_output_enable_n  <= 1'b1;
          o_function_select <= 1'b0;
          cnt_r <= 16'h0000;
          st_r  <= ST_PRE;
        end
        ST_PRE: begin
          // Standard parts float from CAS rise; extended-output parts only after the
          // later strobe, so the precharge count restarts from the RAS rise.
          o_ras_n <= 1'b1; // RL8
          if (o_ras_n) begin
            hold_r <= 1'b0; // RL10
            st_r   <= ST_IDLE;
          end else begin
            cnt_r <= 16'(((RP_CYC > OFF_CYC) ? RP_CYC : OFF_CYC) - 1); // RL8
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule : vd_ctrl

// [tb/vd_monitor.sv]
// Checker for the controller's random-port pins.
// Assumes it is bound into vd_ctrl and sees only its ports.
`timescale 1ns/1ps
module vd_monitor #(parameter int PWRUP_CYC = 20) (
  input wire logic i_clk, i_rst, o_ras_n, o_cas_n, o_upper_byte_write_enable_n,
  input wire logic o_transfer_output_enable_n, o_function_select, o_dq_oe
);
  int cnt_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) cnt_r <= 0;
    else if (cnt_r < 100000) cnt_r <= cnt_r + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_power_wait: assert property (cnt_r < PWRUP_CYC |-> o_ras_n)
    else $error("row strobe too early");
  a_dummy_only: assert property (cnt_r < PWRUP_CYC + 38 |-> o_cas_n)
    else $error("column strobe during init");
  a_xfer_hold: assert property ($fell(o_ras_n) && !o_transfer_output_enable_n
    |=> !o_transfer_output_enable_n) else $error("transfer low not held");
  a_early_data: assert property ($fell(o_cas_n) && !o_ras_n
    && !o_upper_byte_write_enable_n |-> o_dq_oe) else $error("no data at early write");
  a_fsel_hold: assert property ($fell(o_cas_n) |=> $stable(o_function_select))
    else $error("select moved at column strobe");
  c_xfer: cover property ($fell(o_ras_n) && !o_transfer_output_enable_n);
  c_cbr: cover property ($fell(o_cas_n) && o_ras_n);
  c_late: cover property ($fell(o_upper_byte_write_enable_n) && !o_cas_n);
endmodule : vd_monitor
bind vd_ctrl vd_monitor #(.PWRUP_CYC(PWRUP_CYC)) vd_monitor_inst (.*);

// [tb/vd_dram_model.sv]
// Behavioural video DRAM: one word per column with rows aliased, counting serial data.
// Assumes the bench resolves the data wires; a floated bus shows the inverse of its last value.
`timescale 1ns/1ps
module vd_dram_model (
  input wire logic ras_n, cas_n, uwe_n, lwe_n, oe_n, sc,
  input wire logic [8:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout, serial_data_pins
);
  logic [15:0] mem [512];
  logic [15:0] last;
  logic [8:0] col;
  logic early, drv;
  initial begin
    early = 0; col = 0; last = 0; serial_data_pins = 0;
  end
  // Strobes and data leave the controller on one edge, so let them settle first.
  always @(negedge cas_n) if (!ras_n) begin
    #1 col = addr;
    early = !uwe_n || !lwe_n;
    if (!uwe_n) mem[col][15:8] = din[15:8];
    if (!lwe_n) mem[col][7:0] = din[7:0];
  end
  always @(negedge uwe_n) if (!cas_n && !early) #1 mem[col][15:8] = din[15:8];
  always @(negedge lwe_n) if (!cas_n && !early) #1 mem[col][7:0] = din[7:0];
  assign drv = !ras_n && !cas_n && !oe_n && uwe_n && lwe_n && !early;
  always @* if (drv) last = mem[col];
  assign dout = drv ? mem[col] : ~last;
  always @(posedge sc) serial_data_pins <= serial_data_pins + 16'h0001;
endmodule : vd_dram_model

// [tb/tb_top.sv]
// Self-checking bench for the video DRAM controller with a device model.
// Assumes design files, monitor and model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import vd_pkg::*;
  logic i_clk, i_rst, i_lclk, i_avs_read, i_avs_write, o_avs_waitrequest, o_ras_n, o_cas_n;
  logic o_upper_byte_write_enable_n, o_lower_byte_write_enable_n, o_transfer_output_enable_n;
  logic o_function_select, o_dq_oe, o_serial_clock_pin, o_serial_enable_pin_n;
  logic o_serial_data_pins_oe, i_serial_half_flag;
  logic [4:0] i_avs_address;
  logic [3:0] i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [8:0] o_addr;
  logic [15:0] o_dq, i_dq, m_dq, o_serial_data_pins, i_serial_data_pins;
  int fail_count, samples_checked;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  assign i_dq = o_dq_oe ? o_dq : m_dq;
  vd_ctrl #(.PWRUP_CYC(20)) vd_ctrl_inst (.*);
  vd_dram_model vd_dram_model_inst (.ras_n(o_ras_n), .cas_n(o_cas_n), .sc(o_serial_clock_pin),
    .uwe_n(o_upper_byte_write_enable_n), .lwe_n(o_lower_byte_write_enable_n),
    .oe_n(o_transfer_output_enable_n), .addr(o_addr), .din(i_dq), .dout(m_dq),
    .serial_data_pins(i_serial_data_pins));
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    i_lclk = 0;
    #1.7;
    forever #3 i_lclk = ~i_lclk;
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a; i_avs_writedata <= d; i_avs_write <= w; i_avs_read <= !w;
    do begin
      @(posedge i_clk); n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    if (n >= 50) fail_count++;
    i_avs_write <= 0; i_avs_read <= 0;
  endtask : bus
  task automatic run(input logic [2:0] c, input logic [15:0] d);
    int n;
    n = 0;
    bus(1, REG_WDATA, {16'h0000, d});
    bus(1, REG_CTRL, {23'h0, 1'b0, 1'b0, 2'b11, 1'b0, c, 1'b1});
    do begin bus(0, REG_STATUS, 0); n++; end while (q[STAT_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) fail_count++;
  endtask : run
  task automatic t_init;
    int n;
    n = 0;
    do begin bus(0, REG_STATUS, 0); n++; end while (q[STAT_INIT] !== 1'b1 && n < 200);
    `CHK(q[STAT_INIT], 1'b1)
    `CHK(q[21:6], 16'hffff)
    `CHK(q[31:23], 9'h1ff)
    $display("init test done");
  endtask : t_init
  task automatic t_rw;
    bus(1, REG_ADDR, 32'h0000_0005);
    run(CMD_EARLY, 16'h1234);
    run(CMD_READ, 16'h0000);
    bus(0, REG_RDATA, 0);
    `CHK(q[15:0], 16'h1234)
    run(CMD_RMW, 16'habcd);
    bus(0, REG_RDATA, 0);
    `CHK(q[15:0], 16'h1234)
    `CHK(vd_dram_model_inst.mem[5], 16'habcd)
    run(CMD_LATE, 16'h5a0f);
    run(CMD_READ, 16'h0000);
    bus(0, REG_RDATA, 0);
    `CHK(q[15:0], 16'h5a0f)
    $display("write read test done");
  endtask : t_rw
  task automatic t_port;
    bus(1, REG_SCTRL, 32'h0000_0001);
    run(CMD_REF, 16'h0000);
    run(CMD_STOP, 16'h0000);
    run(CMD_XFER, 16'h0000);
    run(CMD_SPLIT, 16'h0000);
    `CHK(q[STAT_REFD], 1'b0)
    `CHK(q[STAT_SVAL], 1'b1)
    bus(0, REG_SDATA, 0);
    `CHK(q[15:0], 16'h0001)
    $display("port test done");
  endtask : t_port
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    {i_rst, i_avs_read, i_avs_write, i_serial_half_flag} = 4'h8;
    i_avs_address = 0; i_avs_writedata = 0; i_avs_byteenable = 4'hf;
    fail_count = 0; samples_checked = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    t_init(); t_rw(); t_port(); wrap_up();
  end
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_top
